// *** hdl/flash_regs_pkg.sv ***
package flash_regs_pkg;

   // ************************************************************
   // Register offsets
   // ************************************************************
   localparam logic [7:0] ADDR_LED_ENABLE_PIN_CALIBRATION_CTRL = 8'h05;
   localparam logic [7:0] ADDR_LED_TEMPERATURE_OUTPUT_VOLTAGE = 8'h06;
   localparam logic [7:0] ADDR_BATTERY_DROOP_AND_REVISION = 8'h07;

   // ************************************************************
   // Field positions, first control register
   // ************************************************************
   localparam int CALIBRATION_START_DONE_BIT = 7;
   localparam int POWER_SAVE_ENABLE_BIT = 6;
   localparam int PIN_DIRECTION_BIT = 5;
   localparam int SECOND_STROBE_LEVEL_BIT = 5;
   localparam int PIN_VALUE_BIT = 4;
   localparam int PIN_OUTPUT_TYPE_BIT = 3;
   localparam int SINK_ENABLE_LSB = 0;
   localparam int SINK_COUNT = 3;

   // ************************************************************
   // Field positions, temperature and voltage register
   // ************************************************************
   localparam int LED_TEMP_MONITOR_ENABLE_BIT = 7;
   localparam int LED_OVERHEAT_FLAG_BIT = 6;
   localparam int LED_TEMP_WARNING_FLAG_BIT = 5;
   localparam int SINK_HEADROOM_OK_BIT = 4;
   localparam int OUTPUT_VOLTAGE_CODE_LSB = 0;
   localparam int OUTPUT_VOLTAGE_CODE_WIDTH = 4;

   // ************************************************************
   // Field positions, droop and revision register
   // ************************************************************
   localparam int DROOP_MONITOR_ENABLE_BIT = 7;
   localparam int DROOP_THRESHOLD_CODE_LSB = 4;
   localparam int DROOP_THRESHOLD_CODE_WIDTH = 3;
   localparam int SPARE_BIT = 3;
   localparam int SILICON_REVISION_CODE_LSB = 0;
   localparam int SILICON_REVISION_CODE_WIDTH = 3;

   // ************************************************************
   // Reset values
   // ************************************************************
   localparam logic [7:0] RESET_LED_ENABLE_PIN_CALIBRATION_CTRL = 8'h55;
   localparam logic [7:0] RESET_LED_TEMPERATURE_OUTPUT_VOLTAGE = 8'h09;
   localparam logic [7:0] RESET_BATTERY_DROOP_CTRL = 8'h40;
   localparam logic [7:0] UNMAPPED_READ_VALUE = 8'h00;

   // ************************************************************
   // Modes and carriers
   // ************************************************************
   typedef enum logic [1:0] {
      MODE_SHUTDOWN = 2'h0,
      MODE_VIDEO_LIGHT = 2'h1,
      MODE_FLASH = 2'h2,
      MODE_VOLTAGE_SOURCE = 2'h3
   } mode_type;

   typedef struct packed {
      logic second_strobe_input;
      logic below_warning_threshold;
      logic below_hot_threshold;
      logic headroom_sufficient;
   } sense_in_type;

   typedef struct packed {
      logic power_save_enable;
      logic [SINK_COUNT-1:0] sink_enable;
      logic led_temp_monitor_enable;
      logic [OUTPUT_VOLTAGE_CODE_WIDTH-1:0] output_voltage_code;
      logic droop_monitor_enable;
      logic [DROOP_THRESHOLD_CODE_WIDTH-1:0] droop_threshold_code;
   } ctrl_out_type;

endpackage : flash_regs_pkg

// *** hdl/level_sync.sv ***
`timescale 1ns/1ps
`default_nettype none

module level_sync #(
   parameter int WIDTH = 4,
   parameter int STAGES = 2
) (
   input wire logic i_clk,
   input wire logic i_srst,
   input wire logic [WIDTH-1:0] i_async,
   output logic [WIDTH-1:0] o_sync
);

   // ************************************************************
   // Elaboration checks
   // ************************************************************
   if (STAGES < 2) begin : g_bad_stages
      $error("level_sync needs at least two stages");
   end
   if (WIDTH < 1) begin : g_bad_width
      $error("level_sync needs a width of at least one");
   end

   // ************************************************************
   // Flip-flop chain
   // ************************************************************
   logic [WIDTH-1:0] chain_q [STAGES];

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         for (int i = 0; i < STAGES; i++) begin
            chain_q[i] <= '0;
         end
      end else begin
         chain_q[0] <= i_async;
         for (int i = 1; i < STAGES; i++) begin
            chain_q[i] <= chain_q[i-1];
         end
      end
   end

   assign o_sync = chain_q[STAGES-1];

endmodule : level_sync

`default_nettype wire

// *** hdl/flash_driver_ctrl_status_regs.sv ***
// Summary of operation
// - Writing one to calibration bit starts self-calibration; zero starts nothing.
// - Calibration bit reads zero while running, one when done; cleared only at start.
// - Power-save enable bit turns light-load power-save on or off.
// - Read-only bit returns present level of the second strobe input.
// - Pin direction bit: zero makes pin input, one makes it output.
// - Pin value bit holds the level driven when pin is an output.
// - Output-type bit: zero push-pull, one open-drain.
// - Three sink enable bits each enable their own LED sink independently.
// - Temperature-monitor enable bit turns thermistor sensing on or off.
// - Overheat flag sets below hot threshold; cleared only by writing zero.
// - Overheat flag forces shutdown, latched until software clears the flag.
// - Read-only warning flag sets below warning threshold; cleared by reading.
// - Headroom bit, one sufficient, updated at end of each flash strobe.
// - Reading voltage code returns the latest self-calibration result or written code.
// - Writing voltage code sets regulation target, 3.825V to 5.700V.
// - Droop-monitor enable bit turns battery droop monitoring on or off.
// - Three-bit droop code selects tolerated droop, 50mV to 225mV.
// - Mode select: 00 shutdown, 01 video, 10 flash, 11 voltage source.
`timescale 1ns/1ps
`default_nettype none

module flash_driver_ctrl_status_regs
   import flash_regs_pkg::*;
#(
   parameter logic [SILICON_REVISION_CODE_WIDTH-1:0] SILICON_REVISION = 3'h1, // Arbitrary value
   parameter int SYNC_STAGES = 2
) (
   input wire logic i_clk,
   input wire logic i_srst,
   // Register port behind the serial interface
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   input wire logic [7:0] i_reg_addr,
   input wire logic [7:0] i_reg_wdata,
   output logic [7:0] o_reg_rdata,
   // Analog and pin sense levels
   input wire sense_in_type i_sense,
   // Calibration engine
   output logic o_cal_start,
   input wire logic i_cal_done,
   input wire logic [OUTPUT_VOLTAGE_CODE_WIDTH-1:0] i_cal_result,
   // Flash sequencer
   input wire logic i_strobe_end,
   input wire logic [1:0] i_mode_select,
   input wire logic i_force_voltage_mode,
   output mode_type o_operating_mode,
   output logic o_voltage_mode_active,
   output logic o_overheat_shutdown,
   // General-purpose pin
   input wire logic i_gpio_pin,
   output logic o_gpio_out,
   output logic o_gpio_oe,
   // Settings to the analog blocks
   output ctrl_out_type o_ctrl
);

   // ************************************************************
   // Elaboration checks
   // ************************************************************
   if (SYNC_STAGES < 2) begin : g_bad_sync
      $error("SYNC_STAGES must be at least two");
   end

   // ************************************************************
   // Helpers
   // ************************************************************
   function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] target);
      reg_hit = (addr == target);
   endfunction : reg_hit

   function automatic mode_type decode_mode(input logic [1:0] sel, input logic hot);
      mode_type m;
      case (sel)
         2'h0: m = MODE_SHUTDOWN;
         2'h1: m = MODE_VIDEO_LIGHT;
         2'h2: m = MODE_FLASH;
         2'h3: m = MODE_VOLTAGE_SOURCE;
         default: m = MODE_SHUTDOWN;
      endcase
      if (hot) begin
         m = MODE_SHUTDOWN;
      end
      decode_mode = m;
   endfunction : decode_mode

   // ************************************************************
   // Synchronisers for pin and comparator levels
   // ************************************************************
   logic [4:0] async_levels;
   logic [4:0] sync_levels;
   logic strobe_level;
   logic warn_level;
   logic hot_level;
   logic headroom_level;
   logic gpio_level;

   assign async_levels = {i_sense.second_strobe_input, i_sense.below_warning_threshold,
                          i_sense.below_hot_threshold, i_sense.headroom_sufficient, i_gpio_pin};

   level_sync #(
      .WIDTH(5),
      .STAGES(SYNC_STAGES)
   ) u_level_sync (
      .i_clk(i_clk),
      .i_srst(i_srst),
      .i_async(async_levels),
      .o_sync(sync_levels)
   );

   assign strobe_level = sync_levels[4];
   assign warn_level = sync_levels[3];
   assign hot_level = sync_levels[2];
   assign headroom_level = sync_levels[1];
   assign gpio_level = sync_levels[0];

   // ************************************************************
   // Access decode
   // ************************************************************
   logic wr_ctrl;
   logic wr_temp;
   logic wr_droop;
   logic rd_temp;

   assign wr_ctrl = i_reg_wr && reg_hit(i_reg_addr, ADDR_LED_ENABLE_PIN_CALIBRATION_CTRL);
   assign wr_temp = i_reg_wr && reg_hit(i_reg_addr, ADDR_LED_TEMPERATURE_OUTPUT_VOLTAGE);
   assign wr_droop = i_reg_wr && reg_hit(i_reg_addr, ADDR_BATTERY_DROOP_AND_REVISION);
   assign rd_temp = i_reg_rd && reg_hit(i_reg_addr, ADDR_LED_TEMPERATURE_OUTPUT_VOLTAGE);

   // ************************************************************
   // Calibration sequence
   // ************************************************************
   typedef enum logic {
      CAL_IDLE,
      CAL_RUN
   } cal_state_type;

   cal_state_type cal_state_q;
   logic cal_done_q;
   logic cal_start_q;
   logic cal_launch;

   assign cal_launch = wr_ctrl && i_reg_wdata[CALIBRATION_START_DONE_BIT];

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         cal_state_q <= CAL_IDLE;
         cal_done_q <= RESET_LED_ENABLE_PIN_CALIBRATION_CTRL[CALIBRATION_START_DONE_BIT];
         cal_start_q <= 1'b0;
      end else begin
         cal_start_q <= cal_launch;
         case (cal_state_q)
            CAL_IDLE: begin
               if (cal_launch) begin
                  cal_state_q <= CAL_RUN;
                  cal_done_q <= 1'b0;
               end
            end
            CAL_RUN: begin
               if (cal_launch) begin
                  cal_done_q <= 1'b0;
               end else if (i_cal_done) begin
                  cal_state_q <= CAL_IDLE;
                  cal_done_q <= 1'b1;
               end
            end
            default: begin
               cal_state_q <= CAL_IDLE;
            end
         endcase
      end
   end

   assign o_cal_start = cal_start_q;

   // ************************************************************
   // First control register: power save, pin, sinks
   // ************************************************************
   logic power_save_q;
   logic pin_direction_q;
   logic pin_value_q;
   logic pin_output_type_q;
   logic [SINK_COUNT-1:0] sink_enable_q;

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         power_save_q <= RESET_LED_ENABLE_PIN_CALIBRATION_CTRL[POWER_SAVE_ENABLE_BIT];
         pin_direction_q <= RESET_LED_ENABLE_PIN_CALIBRATION_CTRL[PIN_DIRECTION_BIT];
         pin_value_q <= RESET_LED_ENABLE_PIN_CALIBRATION_CTRL[PIN_VALUE_BIT];
         pin_output_type_q <= RESET_LED_ENABLE_PIN_CALIBRATION_CTRL[PIN_OUTPUT_TYPE_BIT];
         sink_enable_q <= RESET_LED_ENABLE_PIN_CALIBRATION_CTRL[SINK_ENABLE_LSB +: SINK_COUNT];
      end else if (wr_ctrl) begin
         power_save_q <= i_reg_wdata[POWER_SAVE_ENABLE_BIT];
         pin_direction_q <= i_reg_wdata[PIN_DIRECTION_BIT];
         pin_value_q <= i_reg_wdata[PIN_VALUE_BIT];
         pin_output_type_q <= i_reg_wdata[PIN_OUTPUT_TYPE_BIT];
         sink_enable_q <= i_reg_wdata[SINK_ENABLE_LSB +: SINK_COUNT];
      end
   end

   // ************************************************************
   // General-purpose pin drive
   // ************************************************************
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         o_gpio_out <= 1'b0;
         o_gpio_oe <= 1'b0;
      end else if (pin_output_type_q) begin
         o_gpio_out <= 1'b0;
         o_gpio_oe <= pin_direction_q && !pin_value_q;
      end else begin
         o_gpio_out <= pin_value_q;
         o_gpio_oe <= pin_direction_q;
      end
   end

   // ************************************************************
   // Temperature monitoring
   // ************************************************************
   logic temp_monitor_q;
   logic overheat_q;
   logic warning_q;

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         temp_monitor_q <= RESET_LED_TEMPERATURE_OUTPUT_VOLTAGE[LED_TEMP_MONITOR_ENABLE_BIT];
      end else if (wr_temp) begin
         temp_monitor_q <= i_reg_wdata[LED_TEMP_MONITOR_ENABLE_BIT];
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         overheat_q <= RESET_LED_TEMPERATURE_OUTPUT_VOLTAGE[LED_OVERHEAT_FLAG_BIT];
      end else if (temp_monitor_q && hot_level) begin
         overheat_q <= 1'b1;
      end else if (wr_temp && !i_reg_wdata[LED_OVERHEAT_FLAG_BIT]) begin
         overheat_q <= 1'b0;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         warning_q <= RESET_LED_TEMPERATURE_OUTPUT_VOLTAGE[LED_TEMP_WARNING_FLAG_BIT];
      end else if (temp_monitor_q && warn_level) begin
         warning_q <= 1'b1;
      end else if (rd_temp) begin
         warning_q <= 1'b0;
      end
   end

   assign o_overheat_shutdown = overheat_q;

   // ************************************************************
   // Headroom status
   // ************************************************************
   logic headroom_q;

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         headroom_q <= RESET_LED_TEMPERATURE_OUTPUT_VOLTAGE[SINK_HEADROOM_OK_BIT];
      end else if (i_strobe_end) begin
         headroom_q <= headroom_level;
      end
   end

   // ************************************************************
   // Output voltage code
   // ************************************************************
   logic [OUTPUT_VOLTAGE_CODE_WIDTH-1:0] voltage_code_q;

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         voltage_code_q <= RESET_LED_TEMPERATURE_OUTPUT_VOLTAGE[OUTPUT_VOLTAGE_CODE_LSB +: OUTPUT_VOLTAGE_CODE_WIDTH];
      end else if (cal_state_q == CAL_RUN && i_cal_done && !cal_launch) begin
         voltage_code_q <= i_cal_result;
      end else if (wr_temp) begin
         voltage_code_q <= i_reg_wdata[OUTPUT_VOLTAGE_CODE_LSB +: OUTPUT_VOLTAGE_CODE_WIDTH];
      end
   end

   // ************************************************************
   // Battery droop monitoring
   // ************************************************************
   logic droop_monitor_q;
   logic [DROOP_THRESHOLD_CODE_WIDTH-1:0] droop_code_q;
   logic spare_q;

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         droop_monitor_q <= RESET_BATTERY_DROOP_CTRL[DROOP_MONITOR_ENABLE_BIT];
         droop_code_q <= RESET_BATTERY_DROOP_CTRL[DROOP_THRESHOLD_CODE_LSB +: DROOP_THRESHOLD_CODE_WIDTH];
         spare_q <= RESET_BATTERY_DROOP_CTRL[SPARE_BIT];
      end else if (wr_droop) begin
         droop_monitor_q <= i_reg_wdata[DROOP_MONITOR_ENABLE_BIT];
         droop_code_q <= i_reg_wdata[DROOP_THRESHOLD_CODE_LSB +: DROOP_THRESHOLD_CODE_WIDTH];
         spare_q <= i_reg_wdata[SPARE_BIT];
      end
   end

   // ************************************************************
   // Operating mode
   // ************************************************************
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         o_operating_mode <= MODE_SHUTDOWN;
         o_voltage_mode_active <= 1'b0;
      end else begin
         o_operating_mode <= decode_mode(i_mode_select, overheat_q);
         o_voltage_mode_active <= !overheat_q && (i_force_voltage_mode || i_mode_select == 2'h3);
      end
   end

   // ************************************************************
   // Settings outputs
   // ************************************************************
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         o_ctrl <= '0;
      end else begin
         o_ctrl.power_save_enable <= power_save_q;
         o_ctrl.sink_enable <= sink_enable_q;
         o_ctrl.led_temp_monitor_enable <= temp_monitor_q;
         o_ctrl.output_voltage_code <= voltage_code_q;
         o_ctrl.droop_monitor_enable <= droop_monitor_q;
         o_ctrl.droop_threshold_code <= droop_code_q;
      end
   end

   // ************************************************************
   // Read data
   // ************************************************************
   logic [7:0] rdata_d;
   logic pin_readback;

   assign pin_readback = pin_direction_q ? pin_value_q : gpio_level;

   always_comb begin
      rdata_d = UNMAPPED_READ_VALUE;
      case (i_reg_addr)
         ADDR_LED_ENABLE_PIN_CALIBRATION_CTRL: begin
            rdata_d[CALIBRATION_START_DONE_BIT] = cal_done_q;
            rdata_d[POWER_SAVE_ENABLE_BIT] = power_save_q;
            rdata_d[SECOND_STROBE_LEVEL_BIT] = strobe_level;
            rdata_d[PIN_VALUE_BIT] = pin_readback;
            rdata_d[PIN_OUTPUT_TYPE_BIT] = pin_output_type_q;
            rdata_d[SINK_ENABLE_LSB +: SINK_COUNT] = sink_enable_q;
         end
         ADDR_LED_TEMPERATURE_OUTPUT_VOLTAGE: begin
            rdata_d[LED_TEMP_MONITOR_ENABLE_BIT] = temp_monitor_q;
            rdata_d[LED_OVERHEAT_FLAG_BIT] = overheat_q;
            rdata_d[LED_TEMP_WARNING_FLAG_BIT] = warning_q;
            rdata_d[SINK_HEADROOM_OK_BIT] = headroom_q;
            rdata_d[OUTPUT_VOLTAGE_CODE_LSB +: OUTPUT_VOLTAGE_CODE_WIDTH] = voltage_code_q;
         end
         ADDR_BATTERY_DROOP_AND_REVISION: begin
            rdata_d[DROOP_MONITOR_ENABLE_BIT] = droop_monitor_q;
            rdata_d[DROOP_THRESHOLD_CODE_LSB +: DROOP_THRESHOLD_CODE_WIDTH] = droop_code_q;
            rdata_d[SPARE_BIT] = spare_q;
            rdata_d[SILICON_REVISION_CODE_LSB +: SILICON_REVISION_CODE_WIDTH] = SILICON_REVISION;
         end
         default: begin
            rdata_d = UNMAPPED_READ_VALUE;
         end
      endcase
   end

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         o_reg_rdata <= UNMAPPED_READ_VALUE;
      end else if (i_reg_rd) begin
         o_reg_rdata <= rdata_d;
      end
   end

endmodule : flash_driver_ctrl_status_regs

`default_nettype wire

// *** sim/flash_regs_chk.sv ***
`timescale 1ns/1ps
`default_nettype none
// ************************************************************
// Register bank checks
// ************************************************************
module flash_regs_chk
   import flash_regs_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_srst,
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   input wire logic [7:0] i_reg_addr,
   input wire logic [7:0] i_reg_wdata,
   input wire logic [7:0] o_reg_rdata,
   input wire logic o_cal_start,
   input wire logic i_cal_done,
   input wire logic [OUTPUT_VOLTAGE_CODE_WIDTH-1:0] i_cal_result,
   input wire mode_type o_operating_mode,
   input wire logic o_voltage_mode_active,
   input wire logic o_overheat_shutdown,
   input wire ctrl_out_type o_ctrl
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_srst);
   wire logic wr_ctl = i_reg_wr && i_reg_addr == 8'h05;
   wire logic wr_tmp = i_reg_wr && i_reg_addr == 8'h06;
   wire logic wr_bat = i_reg_wr && i_reg_addr == 8'h07;
   cal_start_a: assert property (wr_ctl && i_reg_wdata[7] |=> o_cal_start) else $error("no calibration start");
   cal_cause_a: assert property (o_cal_start |-> $past(wr_ctl) && $past(i_reg_wdata[7]))
      else $error("calibration start without write");
   cal_busy_a: assert property ($past(wr_ctl) && $past(i_reg_wdata[7]) && i_reg_rd && i_reg_addr == 8'h05
      |=> !o_reg_rdata[7]) else $error("calibration reads done while running");
   ctl_out_a: assert property (wr_ctl |-> ##2 o_ctrl.power_save_enable == $past(i_reg_wdata[6], 2)
      && o_ctrl.sink_enable == $past(i_reg_wdata[2:0], 2)) else $error("power save or sink enable wrong");
   tmp_out_a: assert property (wr_tmp && !i_cal_done |-> ##2
      o_ctrl.led_temp_monitor_enable == $past(i_reg_wdata[7], 2)
      && o_ctrl.output_voltage_code == $past(i_reg_wdata[3:0], 2)) else $error("monitor or voltage code wrong");
   cal_code_a: assert property (i_cal_done |-> ##2
      o_ctrl.output_voltage_code == $past(i_cal_result, 2)) else $error("calibration result not taken");
   droop_out_a: assert property (wr_bat |-> ##2 o_ctrl.droop_monitor_enable == $past(i_reg_wdata[7], 2)
      && o_ctrl.droop_threshold_code == $past(i_reg_wdata[6:4], 2)) else $error("droop settings wrong");
   hot_hold_a: assert property (o_overheat_shutdown && !(wr_tmp && !i_reg_wdata[6])
      |=> o_overheat_shutdown) else $error("overheat flag lost");
   hot_stop_a: assert property (o_overheat_shutdown [*2] |->
      o_operating_mode == MODE_SHUTDOWN && !o_voltage_mode_active) else $error("no shutdown on overheat");
endmodule : flash_regs_chk
bind flash_driver_ctrl_status_regs flash_regs_chk u_chk (.i_clk, .i_srst, .i_reg_wr, .i_reg_rd, .i_reg_addr,
   .i_reg_wdata, .o_reg_rdata, .o_cal_start, .i_cal_done, .i_cal_result, .o_operating_mode,
   .o_voltage_mode_active, .o_overheat_shutdown, .o_ctrl);
`default_nettype wire

// *** sim/cal_engine_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ************************************************************
// Calibration engine model
// ************************************************************
module cal_engine_model
   import flash_regs_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_srst,
   input wire logic i_start,
   input wire logic [7:0] i_delay,
   input wire logic [OUTPUT_VOLTAGE_CODE_WIDTH-1:0] i_code,
   output logic o_done,
   output logic [OUTPUT_VOLTAGE_CODE_WIDTH-1:0] o_result
);
   logic [7:0] cnt_q;
   logic busy_q;
   // Result only valid with the done pulse, changes every cycle otherwise
   always_ff @(posedge i_clk) begin
      o_done <= 1'b0;
      o_result <= ~o_result;
      if (i_srst) begin
         busy_q <= 1'b0;
         cnt_q <= 8'h00;
         o_result <= 4'h5;
      end else if (i_start) begin
         busy_q <= 1'b1;
         cnt_q <= i_delay;
      end else if (busy_q) begin
         cnt_q <= cnt_q - 8'h01;
         if (cnt_q == 8'h00) begin
            busy_q <= 1'b0;
            o_done <= 1'b1;
            o_result <= i_code;
         end
      end
   end
endmodule : cal_engine_model
`default_nettype wire

// *** sim/flash_driver_ctrl_status_regs_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
// ************************************************************
// Register bank testbench
// ************************************************************
module flash_driver_ctrl_status_regs_tb;
   import flash_regs_pkg::*;
   localparam logic [2:0] REV = 3'h5; // Arbitrary value
   logic clk = 1'b0, srst = 1'b1, wr = 1'b0, rd = 1'b0, rd_seen = 1'b0, strobe_end = 1'b0, force_vm = 1'b0;
   logic pin = 1'b0, cal_start, cal_done, gpio_out, gpio_oe, hot, vm_act;
   logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, r;
   logic [7:0] cal_delay = 8'h14;
   logic [3:0] cal_code = 4'h3, cal_res;
   logic [1:0] mode_sel = 2'h0;
   sense_in_type sense = '0;
   mode_type mode;
   ctrl_out_type ctrl;
   logic [7:0] exp_q[$], mask_q[$];
   int num_errors = 0, total_checks = 0, n;
   int seed = 32'h2fc7;
   always #10 clk = ~clk;
   flash_driver_ctrl_status_regs #(.SILICON_REVISION(REV)) u_dut (.i_clk(clk), .i_srst(srst), .i_reg_wr(wr),
      .i_reg_rd(rd), .i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata), .i_sense(sense),
      .o_cal_start(cal_start), .i_cal_done(cal_done), .i_cal_result(cal_res), .i_strobe_end(strobe_end),
      .i_mode_select(mode_sel), .i_force_voltage_mode(force_vm), .o_operating_mode(mode),
      .o_voltage_mode_active(vm_act), .o_overheat_shutdown(hot), .i_gpio_pin(pin), .o_gpio_out(gpio_out),
      .o_gpio_oe(gpio_oe), .o_ctrl(ctrl));
   cal_engine_model u_cal (.i_clk(clk), .i_srst(srst), .i_start(cal_start), .i_delay(cal_delay),
      .i_code(cal_code), .o_done(cal_done), .o_result(cal_res));
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : tally_and_finish
   // One register access per call, the next call releases or replaces it
   task automatic op(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [7:0] e = 8'h00,
      input logic [7:0] m = 8'h00);
      @(posedge clk);
      wr <= w;
      rd <= !w;
      addr <= a;
      wdata <= d;
      if (!w) begin
         exp_q.push_back(e);
         mask_q.push_back(m);
      end
   endtask : op
   task automatic idle(input int k);
      repeat (k) begin
         @(posedge clk);
         wr <= 1'b0;
         rd <= 1'b0;
      end
      @(negedge clk);
   endtask : idle
   task automatic drive(input logic [3:0] s, input logic [1:0] m, input logic f, input logic se);
      @(posedge clk);
      sense <= s;
      pin <= s[3];
      mode_sel <= m;
      force_vm <= f;
      strobe_end <= se;
      wr <= 1'b0;
      rd <= 1'b0;
   endtask : drive
   // Read results compared against the oldest note
   always @(posedge clk) rd_seen <= rd;
   always @(negedge clk) begin
      if (rd_seen) begin
         check("read data", rdata & mask_q.pop_front(), exp_q.pop_front());
      end
   end
   initial begin
      repeat (4) @(posedge clk);
      srst <= 1'b0;
      op(0, 8'h05, 8'h00, 8'h45, 8'hff);
      op(0, 8'h06, 8'h00, 8'h09, 8'hff);
      op(0, 8'h07, 8'h00, {5'h08, REV}, 8'hff);
      op(1, 8'h08, 8'hff);
      op(0, 8'h08, 8'h00, 8'h00, 8'hff);
      op(0, 8'h04, 8'h00, 8'h00, 8'hff);
      repeat (8) begin
         r = 8'($random(seed));
         op(1, 8'h07, r);
         op(0, 8'h07, 8'h00, {r[7:3], REV}, 8'hff);
      end
      idle(1);
      $display("reset and droop test done");
      op(1, 8'h05, 8'hd5);
      op(0, 8'h05, 8'h00, 8'h00, 8'h80);
      idle(1);
      for (n = 0; n < 100 && cal_done !== 1'b1; n++) @(negedge clk);
      check("calibration wait", 8'(n < 100), 8'h01);
      if (n == 100) tally_and_finish;
      op(0, 8'h05, 8'h00, 8'h80, 8'h80);
      op(0, 8'h06, 8'h00, 8'h03, 8'h0f);
      drive(4'h8, 2'h0, 1'b0, 1'b0);
      idle(4);
      op(0, 8'h05, 8'h00, 8'h30, 8'h30);
      idle(1);
      $display("calibration test done");
      for (int k = 0; k < 8; k++) begin
         op(1, 8'h05, {2'b01, k[2:0], 3'b101});
         idle(3);
         check("pin enable", gpio_oe, 8'(k[2] & !(k[0] & k[1])));
         check("pin level", gpio_out, 8'(k[1] & !k[0]));
      end
      $display("pin test done");
      op(1, 8'h06, 8'h83);
      drive(4'h4, 2'h2, 1'b0, 1'b0);
      idle(4);
      drive(4'h2, 2'h2, 1'b0, 1'b0);
      idle(4);
      check("overheat", hot, 8'h01);
      check("mode hot", mode, 8'(MODE_SHUTDOWN));
      op(0, 8'h06, 8'h00, 8'ha3, 8'hbf);
      op(0, 8'h06, 8'h00, 8'h83, 8'hbf);
      drive(4'h0, 2'h2, 1'b0, 1'b0);
      op(1, 8'h06, 8'hc3);
      idle(3);
      check("overheat kept", hot, 8'h01);
      op(1, 8'h06, 8'h83);
      idle(3);
      check("overheat cleared", hot, 8'h00);
      $display("temperature test done");
      for (int m = 0; m < 4; m++) begin
         drive(4'h0, m[1:0], 1'b0, 1'b0);
         idle(3);
         check("mode", mode, 8'(m));
         check("voltage mode", vm_act, 8'(m == 3));
      end
      drive(4'h1, 2'h0, 1'b1, 1'b0);
      idle(3);
      check("forced voltage", vm_act, 8'h01);
      op(1, 8'h06, 8'h0c);
      op(0, 8'h06, 8'h00, 8'h0c, 8'h1f);
      drive(4'h1, 2'h0, 1'b1, 1'b1);
      drive(4'h1, 2'h0, 1'b1, 1'b0);
      op(1, 8'h06, 8'h2c);
      op(0, 8'h06, 8'h00, 8'h1c, 8'h3f);
      idle(2);
      check("notes left", 8'(exp_q.size()), 8'h00);
      $display("mode and headroom test done");
      tally_and_finish;
   end
endmodule : flash_driver_ctrl_status_regs_tb
`default_nettype wire
